// file: core/pfi_core.sv
// Fault propagation, turn-off control, hiccup restart and switching phase.
// Assumes protection detectors are clk-domain levels; sync and fault
// lines are asynchronous pins.
`timescale 1ns/1ps
`include "pfi_defs.svh"

// Notes on behaviour
// - A group wires 1 to 32 converters' fault lines together.
// - With propagation enabled, a faulting converter pulls the fault line.
// - A low fault line starts shutdown even without own fault.
// - A propagated fault causes regular delayed, slewed shutdown.
// - A propagated error causes immediate fast shutdown.
// - The error originator shuts fast and keeps low side on.
// - Regular shutdown honours turn-off delay and falling slew.
// - Non-latching protection retries start-up every 130 ms.
// - Hiccup time runs from output zero, or from a fast turn-off, to next ramp start.
// - Thermal fault and warning monitors are always active.
// - Current and overvoltage monitors arm above pre-bias only.
// - Each protection class has its own turn-off and window.
// - Frequency and phase writes apply only while turned off.
// - Switching locks to the manager's clock on the sync line.
// - Switching frequency selects 500 kHz, 750 kHz or 1 MHz.
// - Frequency choice is independent per converter.
// - PWM starts a programmed delay after the sync edge.
// - Interleave steps are 11.25 degrees, independent of count.
// - Latching protection shuts down and stays off.
// - Fast shutdown opens both switches at once, except an own error, which keeps low side on.
// - A trip clears its status bit to 0, low means active.
module pfi_core
  import pfi_pkg::*;
#(
  parameter int HICCUP_CYC = `PFI_HICCUP_CYC,
  parameter int GROUP_SIZE = `PFI_MAX_GROUP
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Protection detectors
  input  wire logic        det_thermal_warn,
  input  wire logic        det_power_good_bad,
  input  wire logic        det_ramp_follow,
  input  wire logic        det_thermal,
  input  wire logic        det_excess_current,
  input  wire logic        det_low_output,
  input  wire logic        det_high_output,
  // Analog ramp status
  input  wire logic        vout_above_prebias,
  input  wire logic        vout_at_target,
  input  wire logic        vout_at_zero,
  // Shared pins
  input  wire logic        fault_line_in,
  output logic             fault_line_out,
  output logic             fault_line_oe_n,
  input  wire logic        sync_line_in,
  // Power stage control
  output logic             ramp_up_en,
  output logic             ramp_down_en,
  output logic             high_side_en,
  output logic             low_side_on,
  output logic             pwm_start
);
  initial begin
    if (GROUP_SIZE < 1 || GROUP_SIZE > `PFI_MAX_GROUP)
      $error("group size must be 1 to 32");
    if (HICCUP_CYC < 1) $error("hiccup count must be positive");
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic       turn_on_ff;
  logic       prop_en_ff;
  logic       ramp_follow_en_ff;
  logic       ext_err_ff;
  logic [6:0] latch_mask_ff;
  logic [7:0] off_delay_ff;
  logic [1:0] freq_sel_ff;
  logic [4:0] phase_cnt_ff;
  logic [6:0] fault_flag_register_ff;
  logic [7:0] nxt_rdata;
  pfi_state_t state_ff;
  logic [6:0] trips;

  always_ff @(posedge clk) begin
    if (reset) begin
      turn_on_ff        <= 1'b0;
      prop_en_ff        <= 1'b0;
      ramp_follow_en_ff <= 1'b1;
      ext_err_ff        <= 1'b0;
      off_delay_ff      <= 8'h00;
      latch_mask_ff     <= 7'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `PFI_ADDR_CTRL: begin
          turn_on_ff        <= reg_wdata[0];
          prop_en_ff        <= reg_wdata[1];
          ramp_follow_en_ff <= reg_wdata[2];
          ext_err_ff        <= reg_wdata[3];
        end
        `PFI_ADDR_CFG:  latch_mask_ff <= reg_wdata[6:0];
        `PFI_ADDR_STATE: off_delay_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Frequency/phase writes dropped unless converter is off
  always_ff @(posedge clk) begin
    if (reset) begin
      freq_sel_ff  <= `PFI_FREQ_500K;
      phase_cnt_ff <= 5'h00;
    end else if (reg_wr && reg_addr == `PFI_ADDR_FREQ
                 && state_ff == PFI_OFF) begin
      if (reg_wdata[6:5] <= `PFI_FREQ_1M) begin
        freq_sel_ff <= reg_wdata[6:5];
      end
      phase_cnt_ff <= reg_wdata[4:0];
    end
  end

  always_comb begin
    case (reg_addr)
      `PFI_ADDR_CTRL:  nxt_rdata = {4'h0, ext_err_ff, ramp_follow_en_ff,
                                    prop_en_ff, turn_on_ff};
      `PFI_ADDR_CFG:   nxt_rdata = {1'b0, latch_mask_ff};
      `PFI_ADDR_FREQ:  nxt_rdata = {1'b0, freq_sel_ff, phase_cnt_ff};
      `PFI_ADDR_STAT:  nxt_rdata = {1'b0, fault_flag_register_ff};
      `PFI_ADDR_STATE: nxt_rdata = off_delay_ff;
      default:         nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic fl_s1_ff;
  logic fl_s2_ff;
  logic sy_s1_ff;
  logic sy_s2_ff;
  logic sy_s3_ff;
  logic sync_edge;

  always_ff @(posedge clk) begin
    if (reset) begin
      fl_s1_ff <= 1'b1;
      fl_s2_ff <= 1'b1;
      sy_s1_ff <= 1'b0;
      sy_s2_ff <= 1'b0;
      sy_s3_ff <= 1'b0;
    end else begin
      fl_s1_ff <= fault_line_in;
      fl_s2_ff <= fl_s1_ff;
      sy_s1_ff <= sync_line_in;
      sy_s2_ff <= sy_s1_ff;
      sy_s3_ff <= sy_s2_ff;
    end
  end

  assign sync_edge = sy_s2_ff && !sy_s3_ff;

  // ************************************************************
  // Protection qualification
  // ************************************************************
  logic armed_prebias;
  logic own_fast;
  logic own_error;
  logic own_any;
  logic ext_low;
  logic latched_trip;
  logic oe_n_ff;

  assign armed_prebias = vout_above_prebias
                         && state_ff != PFI_OFF;
  assign trips[`PFI_BIT_TW]  = det_thermal_warn;
  assign trips[`PFI_BIT_PGW] = det_power_good_bad && state_ff == PFI_STEADY;
  assign trips[`PFI_BIT_TR]  = det_ramp_follow && ramp_follow_en_ff
                               && state_ff == PFI_RAMP_UP;
  assign trips[`PFI_BIT_OT]  = det_thermal;
  assign trips[`PFI_BIT_OC]  = det_excess_current && armed_prebias;
  assign trips[`PFI_BIT_UV]  = det_low_output && state_ff == PFI_STEADY;
  assign trips[`PFI_BIT_OV]  = det_high_output && armed_prebias;

  // Warnings never turn the converter off
  assign own_error = trips[`PFI_BIT_OV];
  assign own_fast  = trips[`PFI_BIT_TR] || trips[`PFI_BIT_OC];
  assign own_any   = |trips[`PFI_BIT_OV:`PFI_BIT_TR];
  // Own pull is masked so the converter never answers its own echo
  assign ext_low   = !fl_s2_ff && oe_n_ff;

  // Status flags: low is active, a live trip wins over clearing write
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_flag_register_ff <= `PFI_ST_RESET;
    end else begin
      fault_flag_register_ff <= (fault_flag_register_ff
        | ((reg_wr && reg_addr == `PFI_ADDR_STAT) ? reg_wdata[6:0] : 7'h00))
        & ~trips;
    end
  end

  assign latched_trip = |(~fault_flag_register_ff & latch_mask_ff
                          & `PFI_SHUT_MASK);

  // ************************************************************
  // Sequencer
  // ************************************************************
  logic        err_mode_ff;
  logic        ls_hold_ff;
  logic [7:0]  dly_cnt_ff;
  logic [31:0] hic_cnt_ff;
  logic        go_fast;
  logic        go_reg;

  // Own error or fast fault, or a low line read as a propagated error
  assign go_fast = own_error || own_fast
                   || (ext_low && ext_err_ff);
  assign go_reg  = trips[`PFI_BIT_OT] || trips[`PFI_BIT_UV] || ext_low
                   || !turn_on_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff    <= PFI_OFF;
      err_mode_ff <= 1'b0;
      ls_hold_ff  <= 1'b0;
      dly_cnt_ff  <= 8'h00;
      hic_cnt_ff  <= '0;
    end else begin
      case (state_ff)
        PFI_OFF: begin
          hic_cnt_ff <= '0;
          if (turn_on_ff && !own_any && !ext_low && !latched_trip) begin
            state_ff   <= PFI_RAMP_UP;
            ls_hold_ff <= 1'b0;
          end
        end
        PFI_RAMP_UP, PFI_STEADY: begin
          if (go_fast) begin
            state_ff    <= PFI_RAMP_DN;
            err_mode_ff <= 1'b1;
            ls_hold_ff  <= own_error;
          end else if (go_reg) begin
            state_ff   <= PFI_DELAY;
            dly_cnt_ff <= off_delay_ff;
          end else if (state_ff == PFI_RAMP_UP && vout_at_target) begin
            state_ff <= PFI_STEADY;
          end
        end
        PFI_DELAY: begin
          if (go_fast) begin
            state_ff    <= PFI_RAMP_DN;
            err_mode_ff <= 1'b1;
            ls_hold_ff  <= own_error;
          end else if (dly_cnt_ff == 8'h00) begin
            state_ff <= PFI_RAMP_DN;
          end else begin
            dly_cnt_ff <= dly_cnt_ff - 8'h01;
          end
        end
        PFI_RAMP_DN: begin
          if (vout_at_zero || err_mode_ff) begin
            state_ff    <= PFI_HICCUP;
            err_mode_ff <= 1'b0;
            hic_cnt_ff  <= '0;
          end
        end
        PFI_HICCUP: begin
          if (latched_trip || !turn_on_ff) begin
            state_ff <= PFI_OFF;
          end else if (hic_cnt_ff >= 32'(HICCUP_CYC - 1)) begin
            state_ff <= PFI_OFF;
          end else begin
            hic_cnt_ff <= hic_cnt_ff + 32'h1;
          end
        end
        default: state_ff <= PFI_OFF;
      endcase
    end
  end

  // Fault line held low from trip until the hiccup wait starts: output zero, or just after a fast turn-off
  always_ff @(posedge clk) begin
    if (reset) begin
      oe_n_ff <= 1'b1;
    end else if (prop_en_ff && own_any && state_ff != PFI_OFF
                 && state_ff != PFI_HICCUP) begin
      oe_n_ff <= 1'b0;
    end else if (state_ff == PFI_HICCUP || state_ff == PFI_OFF) begin
      oe_n_ff <= 1'b1;
    end
  end

  assign fault_line_oe_n = oe_n_ff;
  assign fault_line_out  = 1'b0;

  // ************************************************************
  // Power stage outputs
  // ************************************************************
  assign ramp_up_en   = state_ff == PFI_RAMP_UP;
  assign ramp_down_en = state_ff == PFI_RAMP_DN && !err_mode_ff;
  assign high_side_en = state_ff == PFI_RAMP_UP || state_ff == PFI_STEADY
                        || state_ff == PFI_DELAY || ramp_down_en;
  assign low_side_on  = ls_hold_ff && !(state_ff == PFI_RAMP_UP);

  pfi_phase_gen #(
    .PER_W (8)
  ) u_phase (
    .clk       (clk),
    .reset     (reset),
    .run       (high_side_en),
    .freq_sel  (freq_sel_ff),
    .phase_cnt (phase_cnt_ff),
    .sync_edge (sync_edge),
    .pwm_start (pwm_start)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  a_ext_shutdown: assert property (@(posedge clk) disable iff (reset)
    (state_ff == PFI_STEADY && ext_low && !go_fast) |=> state_ff == PFI_DELAY)
    else $error("low fault line did not start shutdown");
  a_fast_off: assert property (@(posedge clk) disable iff (reset)
    (state_ff == PFI_STEADY && own_fast) |=> !high_side_en)
    else $error("fast shutdown left high side on");
  a_error_ls: assert property (@(posedge clk) disable iff (reset)
    (state_ff == PFI_STEADY && own_error) |=> low_side_on)
    else $error("error did not hold low side");
  a_line_pull: assert property (@(posedge clk) disable iff (reset)
    (prop_en_ff && own_any && state_ff == PFI_STEADY) |=> !fault_line_oe_n)
    else $error("fault line not pulled");
  a_line_hold: assert property (@(posedge clk) disable iff (reset)
    ($fell(fault_line_oe_n) ##1 state_ff == PFI_RAMP_DN) |-> !fault_line_oe_n)
    else $error("fault line released before output zero");
  a_delay_kept: assert property (@(posedge clk) disable iff (reset)
    (state_ff == PFI_DELAY && dly_cnt_ff != 8'h00 && !go_fast)
    |=> state_ff == PFI_DELAY)
    else $error("turn-off delay cut short");
  a_flag_clear: assert property (@(posedge clk) disable iff (reset)
    trips[`PFI_BIT_OV] |=> !fault_flag_register_ff[`PFI_BIT_OV])
    else $error("trip did not clear status bit");
  a_freq_lock: assert property (@(posedge clk) disable iff (reset)
    (state_ff != PFI_OFF) |=> $stable(freq_sel_ff) && $stable(phase_cnt_ff))
    else $error("frequency changed while running");
  a_hiccup_min: assert property (@(posedge clk) disable iff (reset)
    (state_ff == PFI_HICCUP && !latched_trip && turn_on_ff
     && hic_cnt_ff < 32'(HICCUP_CYC - 1)) |=> state_ff == PFI_HICCUP)
    else $error("hiccup ended early");
  a_prebias_arm: assert property (@(posedge clk) disable iff (reset)
    !vout_above_prebias |-> !trips[`PFI_BIT_OV] && !trips[`PFI_BIT_OC])
    else $error("monitor armed below pre-bias");
  a_ext_fast: assert property (@(posedge clk) disable iff (reset)
    (state_ff == PFI_STEADY && ext_low && ext_err_ff && !own_error)
    |=> !high_side_en && !low_side_on)
    else $error("propagated error did not turn off fast");

  c_hiccup: cover property (@(posedge clk) disable iff (reset)
    state_ff == PFI_HICCUP ##1 state_ff == PFI_OFF);
  c_ext_off: cover property (@(posedge clk) disable iff (reset)
    ext_low && state_ff == PFI_STEADY);
  c_err_off: cover property (@(posedge clk) disable iff (reset)
    own_error && state_ff == PFI_STEADY);
  c_ext_err: cover property (@(posedge clk) disable iff (reset)
    ext_low && ext_err_ff && state_ff == PFI_STEADY);
  c_pwm: cover property (@(posedge clk) disable iff (reset) pwm_start);
endmodule : pfi_core

// file: core/pfi_defs.svh
// Constants for the fault-propagation and interleave block.
// Assumes inclusion by bare name from core design files only.
`ifndef PFI_DEFS_SVH
`define PFI_DEFS_SVH

`define PFI_CLK_HZ        100000000
`define PFI_HICCUP_MS     130
`define PFI_HICCUP_CYC    (`PFI_CLK_HZ / 1000 * `PFI_HICCUP_MS)
`define PFI_MAX_GROUP     32
`define PFI_PHASE_STEPS   32
`define PFI_FREQ_500K     2'h0
`define PFI_FREQ_750K     2'h1
`define PFI_FREQ_1M       2'h2
`define PFI_PER_500K      200
`define PFI_PER_750K      133
`define PFI_PER_1M        100
`define PFI_ST_RESET      7'h7F
`define PFI_SHUT_MASK     7'h7C
`define PFI_BIT_TW        0
`define PFI_BIT_PGW       1
`define PFI_BIT_TR        2
`define PFI_BIT_OT        3
`define PFI_BIT_OC        4
`define PFI_BIT_UV        5
`define PFI_BIT_OV        6
`define PFI_ADDR_CTRL     4'h0
`define PFI_ADDR_CFG      4'h1
`define PFI_ADDR_FREQ     4'h2
`define PFI_ADDR_STAT     4'h3
`define PFI_ADDR_STATE    4'h4

`endif

// file: core/pfi_pkg.sv
// Types shared by the fault-propagation and interleave block.
// Assumes nothing of its surroundings.
package pfi_pkg;
  typedef enum logic [5:0] {
    PFI_OFF     = 6'h01,
    PFI_RAMP_UP = 6'h02,
    PFI_STEADY  = 6'h04,
    PFI_DELAY   = 6'h08,
    PFI_RAMP_DN = 6'h10,
    PFI_HICCUP  = 6'h20
  } pfi_state_t;
endpackage : pfi_pkg

// file: core/pfi_phase_gen.sv
// Switching-phase generator locked to the sync line edge.
// Assumes sync_edge is a one-cycle pulse already in the clk domain.
`timescale 1ns/1ps
`include "pfi_defs.svh"
module pfi_phase_gen
  import pfi_pkg::*;
#(
  parameter int PER_W = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             run,
  input  wire logic [1:0]       freq_sel,
  input  wire logic [4:0]       phase_cnt,
  input  wire logic             sync_edge,
  // Output
  output logic                  pwm_start
);
  initial begin
    if (PER_W < 8) $error("PER_W too small for switching period");
  end

  logic [PER_W-1:0] period;
  logic [PER_W-1:0] delay;
  logic [PER_W-1:0] cnt_ff;
  logic [PER_W-1:0] phase_ff;
  logic             armed_ff;

  always_comb begin
    case (freq_sel)
      `PFI_FREQ_750K: period = PER_W'(`PFI_PER_750K);
      `PFI_FREQ_1M:   period = PER_W'(`PFI_PER_1M);
      default:        period = PER_W'(`PFI_PER_500K);
    endcase
  end

  // Phase delay = (count * period) / 32
  assign delay = PER_W'((32'(period) * 32'(phase_cnt)) / `PFI_PHASE_STEPS);

  // Free-running period counter, realigned on every master edge
  always_ff @(posedge clk) begin
    if (reset || sync_edge || cnt_ff >= period - PER_W'(1)) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + PER_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_ff <= '0;
      armed_ff <= 1'b0;
    end else if (sync_edge) begin
      phase_ff <= delay;
      armed_ff <= 1'b1;
    end
  end

  assign pwm_start = run && armed_ff && (cnt_ff == phase_ff);

  a_pwm_phase: assert property (@(posedge clk) disable iff (reset)
    sync_edge |=> cnt_ff == '0 && phase_ff == $past(delay))
    else $error("phase not realigned on sync edge");
endmodule : pfi_phase_gen

// file: sim/pfi_power_manager_model.sv
// Power manager and peer converters seen from one converter's pins.
// Assumes the bench drives peer_pull and wires the resolved lines back.
`timescale 1ns/1ps
module pfi_power_manager_model #(
  parameter real SYNC_HALF_NS = 1000.0
) (
  // Converter pins
  input  wire logic dut_oe_n,
  input  wire logic dut_out,
  // Peer and relay control
  input  wire logic peer_pull,
  input  wire logic relay_en,
  // Shared lines
  output logic      fault_line,
  output logic      sync_line,
  output logic      other_group_low
);
  // ****************************************
  // Group line, relay and master clock
  // ****************************************
  // Pulled-up line: this converter plus up to 31 peers share it
  assign fault_line = (dut_oe_n ? 1'b1 : dut_out) & ~peer_pull;
  // Low group line is relayed to the other selected groups; the same
  // relay stands for the front-end off and crowbar command
  assign other_group_low = relay_en & ~fault_line;

  // Master clock at 500 kHz, phase unrelated to clk
  initial begin
    sync_line = 1'b0;
    #3.3;
    forever #(SYNC_HALF_NS) sync_line = ~sync_line;
  end
endmodule : pfi_power_manager_model

// file: sim/pol_fault_propagation_interleave_test.sv
// Self-checking bench for the fault-propagation and interleave core.
// Assumes pfi_core and the manager model; reads checked through a queue.
`timescale 1ns/1ps
module pol_fault_propagation_interleave_test;
  import pfi_pkg::*;
  localparam int HCYC = 50;
  localparam int PER [3] = '{200, 133, 100};
  logic       clk, reset, reg_wr, reg_rd, rd_d;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic       d_tw, d_ov, v_pre, v_tgt, v_zero;
  logic       f_line, f_out, f_oe_n, s_line, peer_pull, og_low, relay;
  logic       up_en, dn_en, hs_en, ls_on, pwm, seen;
  logic [2:0] dn_cnt;
  logic [7:0] exp_q [$];
  int         bad_count, cmp_count, n, dly, ph, f, off, gap, base, rnd;

  pfi_core #(.HICCUP_CYC(HCYC)) pfi_core_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .det_thermal_warn(d_tw),
    .det_power_good_bad(1'b0), .det_ramp_follow(1'b0),
    .det_thermal(1'b0), .det_excess_current(1'b0),
    .det_low_output(1'b0), .det_high_output(d_ov),
    .vout_above_prebias(v_pre), .vout_at_target(v_tgt),
    .vout_at_zero(v_zero), .fault_line_in(f_line),
    .fault_line_out(f_out), .fault_line_oe_n(f_oe_n),
    .sync_line_in(s_line), .ramp_up_en(up_en), .ramp_down_en(dn_en),
    .high_side_en(hs_en), .low_side_on(ls_on), .pwm_start(pwm));

  pfi_power_manager_model pfi_power_manager_model_i (
    .dut_oe_n(f_oe_n), .dut_out(f_out), .peer_pull(peer_pull),
    .relay_en(relay), .fault_line(f_line), .sync_line(s_line),
    .other_group_low(og_low));

  // ****************************************
  // Clock, output stage model, read monitor
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Output reaches zero four cycles into a ramp-down
  always @(posedge clk) begin
    dn_cnt <= dn_en ? dn_cnt + 3'h1 : 3'h0;
    v_tgt  <= up_en | (hs_en & ~dn_en);
    v_pre  <= up_en | hs_en;
  end
  assign v_zero = (dn_cnt == 3'h4) || !(up_en | hs_en | dn_en);

  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) chk(reg_rdata, exp_q.pop_front());
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_cnt

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd

  task automatic wait_on();
    for (n = 0; n < 300 && !(hs_en === 1'b1 && up_en === 1'b0); n++) tick();
    chk_cnt(n, 0, 299);
  endtask : wait_on

  // Own overvoltage trip up to the release of the fault line
  task automatic ov_trip();
    @(posedge clk);
    d_ov <= 1'b1;
    @(posedge clk);
    d_ov <= 1'b0;
    for (n = 0; n < 4 && f_oe_n !== 1'b0; n++) tick();
    chk_cnt(n, 0, 3);
    chk(hs_en, 1'b0);
    chk(ls_on, 1'b1);
    for (n = 0; n < 40 && f_oe_n !== 1'b1; n++) tick();
    chk_cnt(n, 1, 39);
  endtask : ov_trip

  task automatic meas();
    logic s0;
    s0 = s_line;
    repeat (500) begin
      tick();
      if (s0 === 1'b0 && s_line === 1'b1) break;
      s0 = s_line;
    end
    for (off = 0; off < 250 && pwm !== 1'b1; off++) tick();
    for (gap = 1; gap < 300; gap++) begin
      tick();
      if (pwm === 1'b1) break;
    end
  endtask : meas

  task automatic tally_and_finish();
    $display("Mismatches %0d in %0d checks", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {d_tw, d_ov, peer_pull, v_pre, v_tgt, dn_cnt} = '0;
    relay = 1'b1;
    rnd = $urandom(32'h346cf988);
    dly = $urandom_range(8, 20);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(4'h3, 8'h7F);
    rd(4'h0, 8'h04);
    rd(4'h2, 8'h00);
    rd(4'h7, 8'h00);
    @(posedge clk);
    d_tw <= 1'b1;
    wr(4'h4, dly[7:0]);
    rd(4'h4, dly[7:0]);
    wr(4'h0, 8'h07);
    wait_on();
    rd(4'h3, 8'h7E);
    chk(hs_en, 1'b1);
    @(posedge clk);
    d_tw <= 1'b0;
    wr(4'h3, 8'h01);
    rd(4'h3, 8'h7F);
    wr(4'h2, 8'h45);
    rd(4'h2, 8'h00);
    ov_trip();
    for (n = 0; n < HCYC + 20 && up_en !== 1'b1; n++) tick();
    chk_cnt(n, HCYC, HCYC + 3);
    rd(4'h3, 8'h3F);
    wr(4'h3, 8'h40);
    rd(4'h3, 8'h7F);
    wait_on();
    // Peer pulls the group line: delayed, ramped turn-off
    @(posedge clk);
    peer_pull <= 1'b1;
    for (n = 0; n < 100 && dn_en !== 1'b1; n++) tick();
    chk_cnt(n, dly + 2, dly + 5);
    chk(f_oe_n, 1'b1);
    chk(ls_on, 1'b0);
    chk(og_low, 1'b1);
    @(posedge clk);
    peer_pull <= 1'b0;
    for (n = 0; n < HCYC + 100 && up_en !== 1'b1; n++) tick();
    chk_cnt(n, HCYC, HCYC + 99);
    wait_on();
    // Latched trip stays off until its flag is written back
    wr(4'h1, 8'h40);
    ov_trip();
    seen = 1'b0;
    repeat (150) begin
      tick();
      seen = seen | (up_en === 1'b1);
    end
    chk(seen, 1'b0);
    wr(4'h3, 8'h40);
    wait_on();
    // Low line read as a propagated error: fast turn-off, low side off
    wr(4'h0, 8'h09);
    rd(4'h0, 8'h09);
    @(posedge clk);
    relay     <= 1'b0;
    peer_pull <= 1'b1;
    for (n = 0; n < 10 && hs_en !== 1'b0; n++) tick();
    chk_cnt(n, 2, 4);
    chk(dn_en, 1'b0);
    chk(ls_on, 1'b0);
    chk(og_low, 1'b0);
    @(posedge clk);
    peer_pull <= 1'b0;
    wait_on();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      f = (i == 0) ? 0 : i - 1;
      ph = (i == 0) ? 0 : $urandom_range(1, 15);
      v = {1'b0, f[1:0], ph[4:0]};
      wr(4'h2, v);
      rd(4'h2, v);
      wr(4'h0, 8'h01);
      wait_on();
      meas();
      if (i == 0) base = off;
      chk_cnt(off - base, PER[f] * ph / 32, PER[f] * ph / 32);
      chk_cnt(gap, PER[f], PER[f]);
    end
    tally_and_finish();
  end
endmodule : pol_fault_propagation_interleave_test
